// >>> mls_unit.sv
// block-copy and load/store execution unit with AXI4-Lite registers
// assumes bus master port, register bus and fbr loader share aclk
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`default_nettype none
module mls_unit
	import mls_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic mem_req,
	output logic mem_write,
	output logic [3:0] mem_cmd,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	output logic [3:0] mem_be,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	input wire logic fbr_load_en,
	input wire logic [7:0] fbr_load_data,
	output logic [7:0] first_byte_received,
	output logic prefetch_flush,
	output logic next_fetch,
	output logic illegal_irq,
	output logic busy
);
	mls_regs_s state_reg;
	mls_regs_s state_next;

	function automatic logic [2:0] beat_bytes(input logic [1:0] lo,
		input logic [23:0] cnt);
		logic [2:0] room;
		room = 3'h4 - {1'b0, lo};
		if (cnt < {21'h0, room})
			beat_bytes = cnt[2:0];
		else
			beat_bytes = room;
	endfunction

	function automatic logic [3:0] lane_mask(input logic [1:0] lo,
		input logic [2:0] nb);
		logic [3:0] m;
		m = 4'h0;
		for (int l = 0; l < 4; l++) begin
			if (l >= int'(lo) && l < int'(lo) + int'(nb))
				m[l] = 1'b1;
		end
		lane_mask = m;
	endfunction

	function automatic logic in_self(input logic [31:0] a,
		input logic [31:0] base);
		in_self = (a[31:7] == base[31:7]);
	endfunction

	function automatic logic [3:0] cmd_of(input logic io, input logic wr);
		if (io)
			cmd_of = wr ? CMD_IO_WR : CMD_IO_RD;
		else
			cmd_of = wr ? CMD_MEM_WR : CMD_MEM_RD;
	endfunction

	function automatic logic addr_ok(input logic [11:0] a);
		addr_ok = (a[11:9] == 3'h1) || (a <= OFF_TEMP && a[1:0] == 2'h0);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] strb);
		logic [31:0] v;
		v = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b])
				v[8*b +: 8] = d[8*b +: 8];
		end
		merge = v;
	endfunction

	always_comb begin
		logic [31:0] ea;
		logic [2:0] nb;
		logic [6:0] idx;
		logic [31:0] word;
		logic wr_io;
		ea = 32'h0;
		nb = 3'h0;
		idx = 7'h0;
		word = 32'h0;
		wr_io = 1'b0;
		state_next = state_reg;
		state_next.flush = 1'b0;
		state_next.next_fetch = 1'b0;
		state_next.ill_pulse = 1'b0;

		// register bus: address and data accepted in either order
		if (s_axi_awvalid && !state_reg.aw_got) begin
			state_next.aw_got = 1'b1;
			state_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !state_reg.w_got) begin
			state_next.w_got = 1'b1;
			state_next.w_data = s_axi_wdata;
			state_next.w_strb = s_axi_wstrb;
		end
		if (state_reg.bvalid && s_axi_bready)
			state_next.bvalid = 1'b0;
		if (state_reg.aw_got && state_reg.w_got && !state_reg.bvalid) begin
			state_next.aw_got = 1'b0;
			state_next.w_got = 1'b0;
			state_next.bvalid = 1'b1;
			state_next.bresp = addr_ok(state_reg.aw_addr) ? RESP_OKAY
				: RESP_SLVERR;
			word = state_reg.w_data;
			case (state_reg.aw_addr)
			OFF_INST0: state_next.inst0 = merge(state_reg.inst0, word,
				state_reg.w_strb);
			OFF_INST1: state_next.inst1 = merge(state_reg.inst1, word,
				state_reg.w_strb);
			OFF_INST2: state_next.inst2 = merge(state_reg.inst2, word,
				state_reg.w_strb);
			OFF_CTRL: begin
				if (state_reg.w_strb[0] && word[CTRL_START] &&
					state_reg.state == ST_IDLE)
					state_next.go = 1'b1;
			end
			OFF_STATUS: begin
				if (state_reg.w_strb[0]) begin
					state_next.done = state_reg.done & ~word[ST_DONE];
					state_next.illegal = state_reg.illegal & ~word[ST_ILL];
				end
			end
			OFF_MODE: if (state_reg.w_strb[0])
				state_next.mode = word[7:0];
			OFF_DCTL: if (state_reg.w_strb[0])
				state_next.dctl = word[7:0];
			OFF_DBASE: state_next.dbase = merge(state_reg.dbase, word,
				state_reg.w_strb);
			OFF_SELFBASE: state_next.self_base = merge(state_reg.self_base,
				word, state_reg.w_strb);
			default: begin
				idx = state_reg.aw_addr[8:2];
				if (state_reg.aw_addr[11:9] == 3'h1 &&
					state_reg.w_strb[0] && idx != FBR_IDX)
					state_next.arr[idx] = word[7:0];
			end
			endcase
		end
		if (state_reg.rvalid && s_axi_rready)
			state_next.rvalid = 1'b0;
		if (s_axi_arvalid && !state_reg.rvalid) begin
			state_next.rvalid = 1'b1;
			state_next.rresp = addr_ok(s_axi_araddr) ? RESP_OKAY
				: RESP_SLVERR;
			case (s_axi_araddr)
			OFF_INST0: state_next.rdata = state_reg.inst0;
			OFF_INST1: state_next.rdata = state_reg.inst1;
			OFF_INST2: state_next.rdata = state_reg.inst2;
			OFF_STATUS: state_next.rdata = {29'h0, state_reg.illegal,
				state_reg.done, state_reg.state != ST_IDLE};
			OFF_MODE: state_next.rdata = {24'h0, state_reg.mode};
			OFF_DCTL: state_next.rdata = {24'h0, state_reg.dctl};
			OFF_DBASE: state_next.rdata = state_reg.dbase;
			OFF_PSAVE: state_next.rdata = state_reg.psave;
			OFF_CMDCNT: state_next.rdata = {state_reg.cmd, state_reg.bcnt};
			OFF_SELFBASE: state_next.rdata = state_reg.self_base;
			OFF_TEMP: state_next.rdata = state_reg.temp;
			default: begin
				if (s_axi_araddr[11:9] == 3'h1)
					state_next.rdata = {24'h0,
						state_reg.arr[s_axi_araddr[8:2]]};
				else
					state_next.rdata = 32'h0;
			end
			endcase
		end

		// fbr is loaded only through the fbr_load_en port
		if (fbr_load_en)
			state_next.arr[FBR_IDX] = fbr_load_data;

		case (state_reg.state)
		ST_IDLE: begin
			if (state_reg.go) begin
				state_next.go = 1'b0;
				state_next.cmd = state_reg.inst0[31:24];
				state_next.bcnt = state_reg.inst0[23:0];
				state_next.psave = state_reg.inst1;
				state_next.state = ST_DECODE;
			end
		end
		ST_DECODE: begin
			if (state_reg.cmd[7:5] == 3'b111) begin
				if (state_reg.cmd[4])
					ea = state_reg.dbase + {{8{state_reg.psave[23]}},
						state_reg.psave[23:0]};
				else
					ea = state_reg.psave;
				wr_io = state_reg.cmd[0] ? state_reg.mode[MODE_SRC_IO]
					: state_reg.mode[MODE_DST_IO];
				if (!state_reg.cmd[0] && state_reg.dctl[DCTL_PFEN] &&
					!state_reg.cmd[1])
					state_next.flush = 1'b1;
				state_next.ls_self = in_self(ea, state_reg.self_base);
				state_next.mem_req = 1'b1;
				state_next.mem_write = !state_reg.cmd[0];
				state_next.mem_cmd = cmd_of(wr_io,
					!state_reg.cmd[0]);
				state_next.mem_addr = ea;
				state_next.mem_be = lane_mask(ea[1:0],
					state_reg.bcnt[2:0]);
				for (int l = 0; l < 4; l++) begin
					idx = state_reg.inst0[22:16] + 7'(l) -
						{5'h0, ea[1:0]};
					state_next.mem_wdata[8*l +: 8] = state_reg.arr[idx];
				end
				state_next.state = ST_LS;
			end else if (state_reg.cmd[7:5] == 3'b110 &&
				state_reg.cmd[4:1] == 4'h0 &&
				state_reg.psave[1:0] == state_reg.inst2[1:0]) begin
				state_next.temp = state_reg.inst2;
				state_next.rd_left = state_reg.bcnt;
				state_next.fcnt = 3'h0;
				if (state_reg.dctl[DCTL_PFEN] && !state_reg.cmd[0])
					state_next.flush = 1'b1;
				state_next.state = ST_MRD;
			end else begin
				state_next.illegal = 1'b1;
				state_next.ill_pulse = 1'b1;
				state_next.state = ST_IDLE;
			end
		end
		ST_MRD: begin
			nb = beat_bytes(state_reg.psave[1:0], state_reg.rd_left);
			if (state_reg.rd_left == 24'h0 || state_reg.fcnt == BURST) begin
				state_next.widx = 3'h0;
				if (state_reg.fcnt == 3'h0)
					state_next.state = ST_FINISH;
				else
					state_next.state = ST_MWR;
			end else if (in_self(state_reg.psave,
				state_reg.self_base)) begin
				for (int b = 0; b < 4; b++)
					word[8*b +: 8] = state_reg.arr[{state_reg.psave[6:2],
						2'(b)}];
				state_next.fifo[state_reg.fcnt[1:0]] = word;
				state_next.psave = state_reg.psave + {29'h0, nb};
				state_next.rd_left = state_reg.rd_left - {21'h0, nb};
				state_next.fcnt = state_reg.fcnt + 3'h1;
			end else if (!state_reg.mem_req) begin
				state_next.mem_req = 1'b1;
				state_next.mem_write = 1'b0;
				state_next.mem_cmd = cmd_of(state_reg.mode[MODE_SRC_IO],
					1'b0);
				state_next.mem_addr = state_reg.psave;
				state_next.mem_be = lane_mask(state_reg.psave[1:0], nb);
			end else if (mem_ack) begin
				state_next.mem_req = 1'b0;
				state_next.fifo[state_reg.fcnt[1:0]] = mem_rdata;
				state_next.psave = state_reg.psave + {29'h0, nb};
				state_next.rd_left = state_reg.rd_left - {21'h0, nb};
				state_next.fcnt = state_reg.fcnt + 3'h1;
			end
		end
		ST_MWR: begin
			nb = beat_bytes(state_reg.temp[1:0], state_reg.bcnt);
			word = state_reg.fifo[state_reg.widx[1:0]];
			if (state_reg.widx == state_reg.fcnt) begin
				state_next.fcnt = 3'h0;
				if (state_reg.bcnt == 24'h0)
					state_next.state = ST_FINISH;
				else
					state_next.state = ST_MRD;
			end else if (in_self(state_reg.temp,
				state_reg.self_base)) begin
				for (int b = 0; b < 4; b++) begin
					idx = {state_reg.temp[6:2], 2'(b)};
					if (lane_mask(state_reg.temp[1:0], nb)
						[b] && idx != FBR_IDX)
						state_next.arr[idx] = word[8*b +: 8];
				end
				state_next.temp = state_reg.temp + {29'h0, nb};
				state_next.bcnt = state_reg.bcnt - {21'h0, nb};
				state_next.widx = state_reg.widx + 3'h1;
			end else if (!state_reg.mem_req) begin
				state_next.mem_req = 1'b1;
				state_next.mem_write = 1'b1;
				state_next.mem_cmd = cmd_of(state_reg.mode[MODE_DST_IO],
					1'b1);
				state_next.mem_addr = state_reg.temp;
				state_next.mem_wdata = word;
				state_next.mem_be = lane_mask(state_reg.temp[1:0], nb);
			end else if (mem_ack) begin
				state_next.mem_req = 1'b0;
				state_next.temp = state_reg.temp + {29'h0, nb};
				state_next.bcnt = state_reg.bcnt - {21'h0, nb};
				state_next.widx = state_reg.widx + 3'h1;
			end
		end
		ST_LS: begin
			if (mem_ack) begin
				state_next.mem_req = 1'b0;
				if (state_reg.ls_self) begin
					state_next.illegal = 1'b1;
					state_next.ill_pulse = 1'b1;
					state_next.state = ST_IDLE;
				end else begin
					if (state_reg.cmd[0]) begin
						for (int l = 0; l < 4; l++) begin
							idx = state_reg.cmd[0] ?
								state_reg.inst0[22:16] + 7'(l) -
								{5'h0, state_reg.mem_addr[1:0]} : 7'h0;
							if (state_reg.mem_be[l] && idx != FBR_IDX)
								state_next.arr[idx] =
									mem_rdata[8*l +: 8];
						end
					end
					state_next.state = ST_FINISH;
				end
			end
		end
		ST_FINISH: begin
			state_next.done = 1'b1;
			state_next.next_fetch = 1'b1;
			state_next.state = ST_IDLE;
		end
		default: state_next.state = ST_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= '0;
			state_reg.state <= ST_IDLE;
			state_reg.mode <= MODE_RST;
			state_reg.dctl <= DCTL_RST;
			state_reg.dbase <= DBASE_RST;
			state_reg.self_base <= SELFBASE_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	assign s_axi_awready = !state_reg.aw_got;
	assign s_axi_wready = !state_reg.w_got;
	assign s_axi_bvalid = state_reg.bvalid;
	assign s_axi_bresp = state_reg.bresp;
	assign s_axi_arready = !state_reg.rvalid;
	assign s_axi_rvalid = state_reg.rvalid;
	assign s_axi_rdata = state_reg.rdata;
	assign s_axi_rresp = state_reg.rresp;
	assign mem_req = state_reg.mem_req;
	assign mem_write = state_reg.mem_write;
	assign mem_cmd = state_reg.mem_cmd;
	assign mem_addr = state_reg.mem_addr;
	assign mem_wdata = state_reg.mem_wdata;
	assign mem_be = state_reg.mem_be;
	assign first_byte_received = state_reg.arr[FBR_IDX];
	assign prefetch_flush = state_reg.flush;
	assign next_fetch = state_reg.next_fetch;
	assign illegal_irq = state_reg.ill_pulse;
	assign busy = state_reg.state != ST_IDLE;
endmodule
`default_nettype wire

// >>> mls_pkg.sv
// constants, states and state record for the block-copy / load-store unit
// assumes one clock domain shared with the bus master and register bus
`default_nettype none
package mls_pkg;
	// register byte offsets on the register bus
	localparam logic [11:0] OFF_INST0 = 12'h000;
	localparam logic [11:0] OFF_INST1 = 12'h004;
	localparam logic [11:0] OFF_INST2 = 12'h008;
	localparam logic [11:0] OFF_CTRL = 12'h00c;
	localparam logic [11:0] OFF_STATUS = 12'h010;
	localparam logic [11:0] OFF_MODE = 12'h014;
	localparam logic [11:0] OFF_DCTL = 12'h018;
	localparam logic [11:0] OFF_DBASE = 12'h01c;
	localparam logic [11:0] OFF_PSAVE = 12'h020;
	localparam logic [11:0] OFF_CMDCNT = 12'h024;
	localparam logic [11:0] OFF_SELFBASE = 12'h028;
	localparam logic [11:0] OFF_TEMP = 12'h02c;
	localparam logic [11:0] OFF_ARR = 12'h200;
	// field positions
	localparam int CTRL_START = 0;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_ILL = 2;
	localparam int MODE_SRC_IO = 5;
	localparam int MODE_DST_IO = 4;
	localparam int DCTL_PFEN = 5;
	// reset values
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] DCTL_RST = 8'h00;
	localparam logic [31:0] DBASE_RST = 32'h0000_0000;
	localparam logic [31:0] SELFBASE_RST = 32'hffff_ff80;
	// internal register index that software cannot write
	localparam logic [6:0] FBR_IDX = 7'h08;
	// burst depth of the copy buffer, in words
	localparam logic [2:0] BURST = 3'h4;
	// bus commands
	localparam logic [3:0] CMD_IO_RD = 4'h2;
	localparam logic [3:0] CMD_IO_WR = 4'h3;
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_DECODE = 6'b000010,
		ST_MRD = 6'b000100,
		ST_MWR = 6'b001000,
		ST_LS = 6'b010000,
		ST_FINISH = 6'b100000
	} mls_state_e;

	typedef struct packed {
		mls_state_e state;
		logic go;
		logic [31:0] inst0;
		logic [31:0] inst1;
		logic [31:0] inst2;
		logic [7:0] mode;
		logic [7:0] dctl;
		logic [31:0] dbase;
		logic [31:0] psave;
		logic [31:0] temp;
		logic [7:0] cmd;
		logic [23:0] bcnt;
		logic [23:0] rd_left;
		logic [31:0] self_base;
		logic done;
		logic illegal;
		logic ls_self;
		logic [3:0][31:0] fifo;
		logic [2:0] fcnt;
		logic [2:0] widx;
		logic [127:0][7:0] arr;
		logic mem_req;
		logic mem_write;
		logic [3:0] mem_cmd;
		logic [31:0] mem_addr;
		logic [31:0] mem_wdata;
		logic [3:0] mem_be;
		logic flush;
		logic next_fetch;
		logic ill_pulse;
		logic aw_got;
		logic w_got;
		logic [11:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} mls_regs_s;
endpackage
`default_nettype wire

// >>> mls_unit_monitor.sv
// assertions on the copy / load-store unit ports
// assumes one clock aclk and synchronous reset aresetn
`default_nettype none
module mls_unit_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic mem_req,
	input wire logic mem_write,
	input wire logic [3:0] mem_cmd,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic [3:0] mem_be,
	input wire logic mem_ack,
	input wire logic fbr_load_en,
	input wire logic [7:0] fbr_load_data,
	input wire logic [7:0] first_byte_received,
	input wire logic prefetch_flush,
	input wire logic next_fetch,
	input wire logic illegal_irq,
	input wire logic busy
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	AST_REQ_HOLD: assert property (
		mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
		&& $stable(mem_wdata) && $stable(mem_be) && $stable(mem_cmd))
		else $error("request changed before answer");
	AST_REQ_DROP: assert property (
		mem_req && mem_ack |=> !mem_req)
		else $error("request held after answer");
	AST_CMD_KIND: assert property (
		mem_req |-> mem_cmd[0] == mem_write && mem_cmd[1] && !mem_cmd[3])
		else $error("bad bus command");
	AST_BE_SET: assert property (
		mem_req |-> mem_be != 4'h0)
		else $error("access without lanes");
	AST_ILL_PULSE: assert property (
		illegal_irq |=> !illegal_irq)
		else $error("illegal pulse too long");
	AST_FLUSH_PULSE: assert property (
		prefetch_flush |=> !prefetch_flush)
		else $error("flush pulse too long");
	AST_FBR_KEEP: assert property (
		!fbr_load_en |=> $stable(first_byte_received))
		else $error("first byte changed without load");
	AST_FBR_LOAD: assert property (
		fbr_load_en |=> first_byte_received == $past(fbr_load_data))
		else $error("first byte load lost");
	AST_ILL_ALONE: assert property (
		illegal_irq |-> !next_fetch)
		else $error("illegal and fetch together");
	AST_REQ_BUSY: assert property (
		mem_req |-> busy)
		else $error("request while idle");
	AST_FETCH_IDLE: assert property (
		next_fetch |-> !mem_req)
		else $error("fetch with access open");
	cover property (mem_req && mem_ack && mem_write);
	cover property (illegal_irq);
	cover property (prefetch_flush ##[1:20] next_fetch);
endmodule
`default_nettype wire

// >>> mls_mem_model.sv
// target model for the bus master port: byte memory and access log
// assumes one access at a time; wait_cycles sets the answer delay
`default_nettype none
module mls_mem_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] wait_cycles,
	input wire logic mem_req,
	input wire logic mem_write,
	input wire logic [3:0] mem_cmd,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic [3:0] mem_be,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [logic [31:0]];
	logic [3:0] cmd_q [$];
	logic [31:0] addr_q [$];
	logic [31:0] base;
	int cnt = 0;
	initial begin
		mem_ack = 1'h0;
		mem_rdata = 32'h0;
	end
	// read data toggles whenever no answer is given
	always @(posedge aclk) begin
		base = {mem_addr[31:2], 2'h0};
		if (!aresetn || !mem_req || mem_ack || cnt < wait_cycles) begin
			mem_ack <= 1'h0;
			mem_rdata <= ~mem_rdata;
			cnt = (aresetn && mem_req && !mem_ack) ? cnt + 1 : 0;
		end else begin
			cnt = 0;
			mem_ack <= 1'h1;
			cmd_q.push_back(mem_cmd);
			addr_q.push_back(mem_addr);
			for (int l = 0; l < 4; l++) begin
				if (mem_write && mem_be[l])
					mem[base + l] = mem_wdata[8 * l +: 8];
				mem_rdata[8 * l +: 8] <= mem.exists(base + l) ?
					mem[base + l] : 8'h5a;
			end
		end
	end
endmodule
`default_nettype wire

// >>> mls_unit_tb.sv
// self-checking bench for the copy / load-store unit
// assumes the memory model answers the bus master port
`default_nettype none
module mls_unit_tb
	import mls_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf, wait_cycles = 4'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, fbr_load_en = 1'h0;
	logic [7:0] fbr_load_data = 8'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, mem_req, mem_write, mem_ack, prefetch_flush;
	logic next_fetch, illegal_irq, busy;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, mem_addr, mem_wdata, mem_rdata, rdv;
	logic [31:0] s = 32'hf732;
	logic [3:0] mem_cmd, mem_be;
	logic [7:0] first_byte_received;
	int num_errors = 0, n_checks = 0, n_nf = 0, n_ill = 0, n_fl = 0;
	mls_unit u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_req, .mem_write,
		.mem_cmd, .mem_addr, .mem_wdata, .mem_be, .mem_ack, .mem_rdata,
		.fbr_load_en, .fbr_load_data, .first_byte_received,
		.prefetch_flush, .next_fetch, .illegal_irq, .busy);
	mls_mem_model u_mem (.aclk, .aresetn, .wait_cycles, .mem_req,
		.mem_write, .mem_cmd, .mem_addr, .mem_wdata, .mem_be, .mem_ack,
		.mem_rdata);
	always #10 aclk = ~aclk;
	always @(posedge aclk) begin
		n_nf += int'(next_fetch === 1'h1);
		n_ill += int'(illegal_irq === 1'h1);
		n_fl += int'(prefetch_flush === 1'h1);
	end
	function automatic logic [31:0] rnd();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic give_verdict();
		if (num_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tmo(input int t);
		if (t > 3000) begin
			num_errors++;
			give_verdict();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic fin;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		fin = 1'h0;
		for (int t = 0; !fin; t++) begin
			@(posedge aclk);
			tmo(t);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) begin
				fin = 1'h1;
				rsp = s_axi_bresp;
				s_axi_bready <= 1'h0;
			end
		end
	endtask
	task automatic rd(input logic [11:0] a);
		logic fin;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		fin = 1'h0;
		for (int t = 0; !fin; t++) begin
			@(posedge aclk);
			tmo(t);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) begin
				fin = 1'h1;
				rdv = s_axi_rdata;
				rsp = s_axi_rresp;
				s_axi_rready <= 1'h0;
			end
		end
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		rd(a);
		chk(rdv, e);
	endtask
	// load three words, start, wait for fetch or illegal pulse
	task automatic op(input logic [31:0] w0, w1, w2);
		wr(OFF_INST0, w0);
		wr(OFF_INST1, w1);
		wr(OFF_INST2, w2);
		u_mem.cmd_q.delete();
		u_mem.addr_q.delete();
		wait_cycles <= 4'(rnd() & 32'h7);
		n_nf = 0;
		n_ill = 0;
		n_fl = 0;
		wr(OFF_CTRL, 32'h1);
		for (int t = 0; n_nf + n_ill == 0; t++) begin
			@(posedge aclk);
			tmo(t);
		end
		repeat (2) @(posedge aclk);
	endtask
	task automatic ev(input int nf, input int il, input int nbus);
		chk(32'(n_nf), 32'(nf));
		chk(32'(n_ill), 32'(il));
		chk(32'(u_mem.cmd_q.size()), 32'(nbus));
	endtask
	initial begin
		int cnt, a, beats, k;
		logic [31:0] src, v;
		logic [7:0] e;
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		rdc(OFF_MODE, 32'(MODE_RST));
		rdc(OFF_DCTL, 32'(DCTL_RST));
		rdc(OFF_SELFBASE, SELFBASE_RST);
		rd(12'h100);
		chk(32'(rsp), 32'(RESP_SLVERR));
		for (int i = 0; i < 4; i++) begin
			cnt = 1 + int'(rnd() % 40);
			a = int'(rnd() % 4);
			src = 32'h1000 + a;
			v = rnd();
			for (k = 0; k <= cnt; k++) begin
				u_mem.mem[src + k] = 8'(rnd());
				u_mem.mem[src + 32'h2000 + k] = ~u_mem.mem[src + k];
			end
			beats = 0;
			for (k = 0; k < cnt; k += 4 - (a + k) % 4)
				beats++;
			wr(OFF_MODE, 32'(i << 4));
			wr(OFF_DCTL, 32'(i[0]) << 5);
			wr(OFF_DBASE, v);
			chk(32'(rsp), 32'(RESP_OKAY));
			// equal low address bits on both sides
			op({8'hc0 | 8'(i[1]), 24'(cnt)}, src, src + 32'h2000);
			ev(1, 0, 2 * beats);
			chk(32'(n_fl), 32'(i == 1));
			for (k = 0; k <= cnt; k++) begin
				e = k < cnt ? u_mem.mem[src + k] : ~u_mem.mem[src + k];
				chk(32'(u_mem.mem[src + 32'h2000 + k]), 32'(e));
			end
			foreach (u_mem.cmd_q[j])
				chk(32'(u_mem.cmd_q[j]), 32'(u_mem.cmd_q[j][0] ?
					(i[0] ? CMD_IO_WR : CMD_MEM_WR) :
					(i[1] ? CMD_IO_RD : CMD_MEM_RD)));
			rdc(OFF_DBASE, v);
		end
		op(32'hc000_0000, 32'h1000, 32'h3000);
		ev(1, 0, 0);
		// bit 29 set decodes as load/store, so an unused opcode stands in
		for (k = 25; k < 31; k++) begin
			op(k < 29 ? 32'hc000_0004 | (32'h1 << k) :
				(k == 29 ? 32'h8000_0004 : 32'hc000_0004),
				32'h1000, k < 30 ? 32'h3000 : 32'h3002);
			ev(0, 1, 0);
		end
		wr(OFF_MODE, 32'h30);
		for (k = 0; k < 2; k++) begin
			u_mem.mem[32'h2000] = 8'h5a;
			for (int j = 0; j < 3; j++)
				wr(OFF_ARR + 12'(4 * (17 + j)), 32'h0a1 + j + k);
			op({8'he0 | 8'(k << 1), 24'h11_0003}, 32'h2001, 32'h0);
			ev(1, 0, 1);
			chk(32'(n_fl), 32'(k == 0));
			chk(32'(u_mem.cmd_q[0]), 32'(CMD_IO_WR));
			chk(32'(u_mem.mem[32'h2000]), 32'h5a);
			for (int j = 0; j < 3; j++)
				chk(32'(u_mem.mem[32'h2001 + j]), 32'h0a1 + j + k);
			rdc(OFF_PSAVE, 32'h2001);
			rd(OFF_CMDCNT);
			chk(rdv >> 24, {24'h0, 8'he0 | 8'(k << 1)});
		end
		wr(OFF_DBASE, 32'h2100);
		for (k = 0; k < 4; k++)
			u_mem.mem[32'h2004 + k] = 8'(rnd());
		op(32'hf120_0004, 32'hab_ffff04, 32'h0);
		ev(1, 0, 1);
		chk(32'(n_fl), 32'h0);
		chk(u_mem.addr_q[0], 32'h2004);
		chk(32'(u_mem.cmd_q[0]), 32'(CMD_IO_RD));
		for (k = 0; k < 4; k++)
			rdc(OFF_ARR + 12'(4 * (32 + k)), 32'(u_mem.mem[32'h2004 + k]));
		e = 8'(rnd());
		fbr_load_data <= e;
		fbr_load_en <= 1'h1;
		@(posedge aclk);
		fbr_load_en <= 1'h0;
		@(posedge aclk);
		chk(32'(first_byte_received), 32'(e));
		wr(OFF_ARR + 12'h20, 32'(~e));
		op(32'he108_0001, 32'h2004, 32'h0);
		chk(32'(first_byte_received), 32'(e));
		op(32'he008_0001, 32'h2010, 32'h0);
		chk(32'(u_mem.mem[32'h2010]), 32'(e));
		op(32'he011_0001, SELFBASE_RST | 32'h11, 32'h0);
		ev(0, 1, 1);
		rdc(OFF_STATUS, 32'h6);
		wr(OFF_STATUS, 32'h6);
		rdc(OFF_STATUS, 32'h0);
		op(32'hc000_0004, 32'h1000, SELFBASE_RST | 32'h40);
		ev(1, 0, 1);
		for (k = 0; k < 4; k++)
			rdc(OFF_ARR + 12'(4 * (64 + k)), 32'(u_mem.mem[32'h1000 + k]));
		give_verdict();
	end
endmodule
bind mls_unit mls_unit_monitor u_mon (.aclk, .aresetn, .mem_req,
	.mem_write, .mem_cmd, .mem_addr, .mem_wdata, .mem_be, .mem_ack,
	.fbr_load_en, .fbr_load_data, .first_byte_received, .prefetch_flush,
	.next_fetch, .illegal_irq, .busy);
`default_nettype wire
